// ===== hw/stw_dev.sv
// sensor end of the two-wire serial port
//
// Overview of operation
// - host starts every transfer, one shared wire
// - host alone makes the serial clock
// - write is address byte msb 1, data
// - drive on falling edge, sample on rising
// - read is address msb 0, sensor returns byte
// - host releases wire after last address bit
// - host waits 100 us before read data
// - last read bit high phase 120 ns minimum
// - sensor holds last bit until next fall
// - wire stays released after a write
// - no transfers while power down is high
// - power down releases the data wire
// - power down pulse resyncs transfer machine
// - 0.9 s transaction timeout resets port
// - unmapped write ignored, unmapped read zero
// - host waits 100 us after a write
// - power down mid transfer cancels, no write
`timescale 1ns/1ns
`default_nettype none

module stw_dev #(
  parameter int TMO_CYC = stw_pkg::SPTT_CYC,
  parameter logic [7:0] ID_VAL = 8'h5A // arbitrary identity value
) (
  stw_link_if.dev lnk,              // link to the host
  input wire logic sys_clk,         // core clock
  input wire logic resetn,          // async reset, active low
  output logic upd_valid,           // register written, pulse
  output logic [6:0] upd_addr,      // written address
  output logic [7:0] upd_data,      // written value
  output logic port_busy            // transfer under way
);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] cnt;  // rising edges seen in frame
    logic rd;         // frame is a read
    logic [6:0] addr; // received address
    logic [7:0] wdat; // received write data
    logic rtog;       // read request toggle
    logic wtog;       // write request toggle
    logic open;       // frame under way, registered
  } stw_rx_t;

  typedef struct packed {
    logic oe;         // sensor drives the wire
    logic [7:0] sh;   // outgoing read byte
  } stw_tx_t;

  typedef struct packed {
    logic pd_s1;
    logic pd_s2;
    logic bz_s1;
    logic bz_s2;
    logic rt_s1;
    logic rt_s2;
    logic rt_s3;
    logic wt_s1;
    logic wt_s2;
    logic wt_s3;
    logic [25:0] tmo; // transaction age in core cycles
    logic prst_n;     // serial port out of reset
    logic [7:0] rdat; // byte prepared for a read
    logic uv;
    logic [6:0] ua;
    logic [7:0] ud;
  } stw_core_t;

  stw_rx_t rx_ff;
  stw_rx_t nxt_rx;
  stw_tx_t tx_ff;
  stw_tx_t nxt_tx;
  stw_core_t core_ff;
  stw_core_t nxt_core;
  logic [7:0] regs_ff [1:15];
  logic port_rst_n;
  logic wr_en;
  logic wr_hit;

  // port reset comes from the core, a registered level
  assign port_rst_n = core_ff.prst_n;

  // ----------------------------------------------------------------
  // link side, rising edge: receive address and write data
  // ----------------------------------------------------------------
  // frame counter, moves only on host clock edges or port reset
  always_comb begin
    nxt_rx = rx_ff;
    if (rx_ff.cnt == 5'h00) begin
      // first bit is the direction flag
      nxt_rx.rd = (lnk.sdio != stw_pkg::DIR_WRITE);
      nxt_rx.cnt = 5'h01;
    end else if (rx_ff.cnt <= stw_pkg::CNT_ADDR_LAST) begin
      nxt_rx.addr = {rx_ff.addr[5:0], lnk.sdio};
      nxt_rx.cnt = rx_ff.cnt + 5'h01;
      if (rx_ff.cnt == stw_pkg::CNT_ADDR_LAST && rx_ff.rd) begin
        nxt_rx.rtog = ~rx_ff.rtog; // ask core for the byte
      end
    end else begin
      if (!rx_ff.rd) begin
        nxt_rx.wdat = {rx_ff.wdat[6:0], lnk.sdio};
      end
      if (rx_ff.cnt == stw_pkg::CNT_DATA_LAST) begin
        nxt_rx.cnt = 5'h00;
        if (!rx_ff.rd) begin
          nxt_rx.wtog = ~rx_ff.wtog; // hand write to core
        end
      end else begin
        nxt_rx.cnt = rx_ff.cnt + 5'h01;
      end
    end
    // busy level from a flop, glitch free for the core synchroniser
    nxt_rx.open = (nxt_rx.cnt != 5'h00);
  end

  // port reset clears the frame
  always_ff @(posedge lnk.sclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      rx_ff <= '0;
    end else begin
      rx_ff <= nxt_rx;
    end
  end

  // ----------------------------------------------------------------
  // link side, falling edge: drive read data
  // ----------------------------------------------------------------
  // load, shift, release on falling edges, release also on port reset
  always_comb begin
    nxt_tx = tx_ff;
    if (rx_ff.cnt == 5'h00) begin
      // last bit held through the high phase, dropped here
      nxt_tx.oe = 1'b0; // never on after a write
    end else if (rx_ff.rd && rx_ff.cnt == stw_pkg::CNT_DATA_FIRST) begin
      nxt_tx.oe = 1'b1; // take over the wire
      nxt_tx.sh = core_ff.rdat;
    end else if (rx_ff.rd && rx_ff.cnt > stw_pkg::CNT_DATA_FIRST) begin
      nxt_tx.sh = {tx_ff.sh[6:0], 1'b0}; // msb first
    end
  end

  // power down drops the drive through the port reset, three core clocks after pd rises
  always_ff @(negedge lnk.sclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      tx_ff <= '0;
    end else begin
      tx_ff <= nxt_tx;
    end
  end

  assign lnk.sdio_d_oe = tx_ff.oe; // only during reads
  assign lnk.sdio_d_o = tx_ff.sh[7];

  // ----------------------------------------------------------------
  // core side: crossings, register access, watchdog
  // ----------------------------------------------------------------
  // read lookup, unmapped space reads zero
  function automatic logic [7:0] stw_lookup(input logic [6:0] a);
    logic [7:0] v;
    v = stw_pkg::ZERO_BYTE;
    if (a == stw_pkg::ID_ADDR) begin
      v = ID_VAL;
    end else if (a < stw_pkg::NUM_REGS) begin
      v = regs_ff[a[3:0]];
    end
    return v;
  endfunction : stw_lookup

  // write strobe, dropped under power down
  assign wr_en = (core_ff.wt_s2 != core_ff.wt_s3) && !core_ff.pd_s2 &&
    core_ff.prst_n;

  // only mapped, writable addresses count as a register write
  assign wr_hit = wr_en && rx_ff.addr != stw_pkg::ID_ADDR &&
    rx_ff.addr < stw_pkg::NUM_REGS;

  // synchronisers, request decode and transaction timer
  always_comb begin
    nxt_core = core_ff;
    nxt_core.pd_s1 = lnk.pd;
    nxt_core.pd_s2 = core_ff.pd_s1;
    nxt_core.bz_s1 = rx_ff.open;
    nxt_core.bz_s2 = core_ff.bz_s1;
    nxt_core.rt_s1 = rx_ff.rtog;
    nxt_core.rt_s2 = core_ff.rt_s1;
    nxt_core.rt_s3 = core_ff.rt_s2;
    nxt_core.wt_s1 = rx_ff.wtog;
    nxt_core.wt_s2 = core_ff.wt_s1;
    nxt_core.wt_s3 = core_ff.wt_s2;
    nxt_core.uv = 1'b0;
    // address stays put until the next frame, safe to read here
    if (core_ff.rt_s2 != core_ff.rt_s3) begin
      nxt_core.rdat = stw_lookup(rx_ff.addr);
    end
    if (wr_hit) begin
      nxt_core.uv = 1'b1;
      nxt_core.ua = rx_ff.addr;
      nxt_core.ud = rx_ff.wdat;
    end
    // age of the open frame
    if (core_ff.bz_s2) begin
      nxt_core.tmo = core_ff.tmo + 26'h0000001;
    end else begin
      nxt_core.tmo = 26'h0000000;
    end
    nxt_core.prst_n = !(core_ff.pd_s2 ||
      core_ff.tmo == TMO_CYC[25:0]);
    // while the port is held, forget half-seen requests
    if (!core_ff.prst_n) begin
      nxt_core.bz_s1 = 1'b0;
      nxt_core.bz_s2 = 1'b0;
      nxt_core.rt_s1 = 1'b0;
      nxt_core.rt_s2 = 1'b0;
      nxt_core.rt_s3 = 1'b0;
      nxt_core.wt_s1 = 1'b0;
      nxt_core.wt_s2 = 1'b0;
      nxt_core.wt_s3 = 1'b0;
      nxt_core.tmo = 26'h0000000;
    end
  end

  // core state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // register file, unmapped and identity writes ignored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 1; i < 16; i++) begin
        regs_ff[i] <= stw_pkg::REG_RST;
      end
    end else if (wr_hit) begin
      regs_ff[rx_ff.addr[3:0]] <= rx_ff.wdat;
    end
  end

  // ----------------------------------------------------------------
  // user side outputs
  // ----------------------------------------------------------------
  assign upd_valid = core_ff.uv;
  assign upd_addr = core_ff.ua;
  assign upd_data = core_ff.ud;
  assign port_busy = core_ff.bz_s2;

endmodule : stw_dev

`default_nettype wire

// ===== hw/stw_host.sv
// host end of the two-wire serial port
`timescale 1ns/1ns
`default_nettype none

module stw_host #(
  parameter int RD_WAIT = stw_pkg::RD_PREP_CYC,
  parameter int WR_GAP = stw_pkg::WR_GAP_CYC,
  parameter int PD_MIN = stw_pkg::PD_MIN_CYC
) (
  stw_link_if.host lnk,          // link to the sensor
  input wire logic sys_clk,      // host clock
  input wire logic resetn,       // async reset, active low
  input wire logic cmd_valid,    // command offered
  output logic cmd_ready,        // command taken when both high
  input wire logic cmd_write,    // 1 write, 0 read
  input wire logic [6:0] cmd_addr, // register address
  input wire logic [7:0] cmd_wdata, // write data
  output logic rsp_valid,        // read data valid, pulse
  output logic [7:0] rsp_data,   // read data
  input wire logic pd_req,       // power down request level
  output logic pd_active         // power_down_pin level
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LO = 3'b001,
    ST_HI = 3'b010,
    ST_GAP = 3'b011,
    ST_PD = 3'b100
  } stw_st_t;

  typedef struct packed {
    stw_st_t st;
    logic [15:0] cnt;
    logic [4:0] bitn;
    logic [15:0] sh;
    logic wr;
    logic sclk;
    logic oe;
    logic dout;
    logic pd;
    logic sd_s1;
    logic sd_s2;
    logic [7:0] rdat;
    logic rv;
  } stw_hst_t;

  stw_hst_t h_ff;
  stw_hst_t nxt_h;
  logic [15:0] hi_len;

  // high phase after the last address bit of a read is long
  assign hi_len = (!h_ff.wr && h_ff.bitn == stw_pkg::CNT_ADDR_LAST) ?
    16'(RD_WAIT - 1) : 16'(stw_pkg::HALF_CYC - 1);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // clock divider and bit sequencer in one
  always_comb begin
    nxt_h = h_ff;
    nxt_h.sd_s1 = lnk.sdio;
    nxt_h.sd_s2 = h_ff.sd_s1;
    nxt_h.rv = 1'b0;
    nxt_h.cnt = h_ff.cnt + 16'h0001;
    case (h_ff.st)
      ST_IDLE: begin
        nxt_h.sclk = 1'b1;
        nxt_h.oe = 1'b0;
        if (pd_req) begin
          nxt_h.pd = 1'b1;
          nxt_h.cnt = 16'h0000;
          nxt_h.st = ST_PD;
        end else if (cmd_valid) begin
          // direction flag leads, msb first
          nxt_h.sh = {cmd_write, cmd_addr, cmd_wdata};
          nxt_h.wr = cmd_write;
          nxt_h.bitn = 5'h00;
          nxt_h.cnt = 16'h0000;
          nxt_h.sclk = 1'b0; // host starts the frame
          nxt_h.oe = 1'b1;
          nxt_h.dout = cmd_write; // set on falling edge
          nxt_h.st = ST_LO;
        end
      end
      ST_LO: begin
        if (h_ff.cnt == 16'(stw_pkg::HALF_CYC - 1)) begin
          nxt_h.sclk = 1'b1;
          nxt_h.cnt = 16'h0000;
          nxt_h.st = ST_HI;
        end
      end
      ST_HI: begin
        // release one cycle after the last address rise, so the
        // sensor's sample of that bit never races the release
        if (!h_ff.wr && h_ff.bitn == stw_pkg::CNT_ADDR_LAST) begin
          nxt_h.oe = 1'b0;
        end
        if (h_ff.cnt == hi_len) begin
          nxt_h.cnt = 16'h0000;
          if (!h_ff.wr && h_ff.bitn > stw_pkg::CNT_ADDR_LAST) begin
            nxt_h.rdat = {h_ff.rdat[6:0], h_ff.sd_s2};
          end
          if (h_ff.bitn == stw_pkg::HOST_BIT_LAST) begin
            // high phase already exceeds the hold time
            if (h_ff.wr) begin
              nxt_h.oe = 1'b0;
              nxt_h.st = ST_GAP;
            end else begin
              nxt_h.rv = 1'b1;
              nxt_h.st = ST_IDLE;
            end
          end else begin
            nxt_h.bitn = h_ff.bitn + 5'h01;
            nxt_h.sclk = 1'b0;
            nxt_h.sh = {h_ff.sh[14:0], 1'b0};
            nxt_h.dout = h_ff.sh[14];
            nxt_h.st = ST_LO;
          end
        end
      end
      ST_GAP: begin
        if (h_ff.cnt == 16'(WR_GAP - 1)) begin
          nxt_h.st = ST_IDLE;
        end
      end
      ST_PD: begin
        if (h_ff.cnt >= 16'(PD_MIN - 1)) begin
          nxt_h.cnt = h_ff.cnt;
          if (!pd_req) begin
            nxt_h.pd = 1'b0; // held at least the minimum
            nxt_h.st = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_h.st = ST_IDLE;
      end
    endcase
  end

  // state register, clock idles high
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      h_ff <= '{st: ST_IDLE, sclk: 1'b1, default: '0};
    end else begin
      h_ff <= nxt_h;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready = (h_ff.st == ST_IDLE) && !pd_req;
  assign rsp_valid = h_ff.rv;
  assign rsp_data = h_ff.rdat;
  assign pd_active = h_ff.pd;
  assign lnk.sclk = h_ff.sclk;
  assign lnk.pd = h_ff.pd;
  assign lnk.sdio_h_o = h_ff.dout;
  assign lnk.sdio_h_oe = h_ff.oe;

endmodule : stw_host

`default_nettype wire

// ===== hw/stw_link_if.sv
// link wires between the host end and the sensor end
`timescale 1ns/1ns
`default_nettype none

interface stw_link_if;
  logic sclk;      // serial clock, host made
  logic pd;        // power_down_pin, active high
  logic sdio_h_o;  // host data drive value
  logic sdio_h_oe; // host drives data wire
  logic sdio_d_o;  // sensor data drive value
  logic sdio_d_oe; // sensor drives data wire
  logic sdio;      // resolved wire level

  // wire level, pulled high when nobody drives
  assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b1);

  modport dev (input sclk, input pd, input sdio,
    output sdio_d_o, output sdio_d_oe);
  modport host (output sclk, output pd, output sdio_h_o,
    output sdio_h_oe, input sdio);
endinterface : stw_link_if

`default_nettype wire

// ===== hw/stw_pkg.sv
// shared constants of the two-wire sensor serial port
package stw_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 16;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0F;
  localparam logic [4:0] HOST_BIT_LAST = 5'h0F;

  // ----------------------------------------------------------------
  // register space of the sensor end
  // ----------------------------------------------------------------
  localparam logic [6:0] ID_ADDR = 7'h00;
  localparam logic [6:0] NUM_REGS = 7'h10;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // timing, figures as printed and derived cycle counts
  // ----------------------------------------------------------------
  localparam int SYS_NS = 20;
  localparam int RD_PREP_US = 100;
  localparam int WR_GAP_US = 100;
  localparam int PD_MIN_US = 100;
  localparam int SPTT_MS = 900;
  localparam int HALF_NS = 500;
  localparam int RD_PREP_CYC = (RD_PREP_US * 1000 + SYS_NS - 1) / SYS_NS;
  localparam int WR_GAP_CYC = (WR_GAP_US * 1000 + SYS_NS - 1) / SYS_NS;
  localparam int PD_MIN_CYC = (PD_MIN_US * 1000 + SYS_NS - 1) / SYS_NS;
  localparam int HALF_CYC = (HALF_NS + SYS_NS - 1) / SYS_NS;
  localparam int SPTT_CYC = (SPTT_MS * 1000000) / SYS_NS;

endpackage : stw_pkg

// ===== sim/stw_link_sva.sv
// assertions on the link between host end and sensor end
`timescale 1ns/1ns
`default_nettype none

module stw_link_sva #(
  parameter int RD_WAIT = stw_pkg::RD_PREP_CYC
) (
  input wire logic sys_clk,   // core clock
  input wire logic resetn,    // async reset, active low
  input wire logic sclk,      // serial clock
  input wire logic pd,        // power_down_pin
  input wire logic sdio_h_o,  // host drive value
  input wire logic sdio_h_oe, // host drive enable
  input wire logic sdio_d_o,  // sensor drive value
  input wire logic sdio_d_oe  // sensor drive enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic [15:0] hi_cnt_ff;
  logic [15:0] nxt_hi_cnt;
  logic turn_ff;
  logic nxt_turn;
  logic oe_q_ff;

  // high phase length and read turnaround tracking
  always_comb begin
    nxt_hi_cnt = sclk ? hi_cnt_ff + 16'h0001 : 16'h0000;
    nxt_turn = sclk & (turn_ff | (oe_q_ff & !sdio_h_oe));
  end

  // helper registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_ff <= 16'h0000;
      turn_ff <= 1'b0;
      oe_q_ff <= 1'b0;
    end else begin
      hi_cnt_ff <= nxt_hi_cnt;
      turn_ff <= nxt_turn;
      oe_q_ff <= sdio_h_oe;
    end
  end

  // ----------------------------------------------------------------
  // wire rules
  // ----------------------------------------------------------------
  chk_no_collision: assert property (!(sdio_h_oe && sdio_d_oe))
    else $error("both ends drive the data wire");
  chk_dev_on_fall: assert property (sdio_d_oe && $past(sdio_d_oe) &&
    $changed(sdio_d_o) |-> $fell(sclk))
    else $error("sensor data changed off a falling edge");
  chk_host_hold: assert property (sclk && $past(sclk) &&
    sdio_h_oe && $past(sdio_h_oe) |-> $stable(sdio_h_o))
    else $error("host data changed while clock high");
  chk_sclk_high_min: assert property ($rose(sclk) |-> sclk[*6])
    else $error("clock high phase under 120 ns");
  chk_read_wait: assert property (turn_ff && !sclk |->
    hi_cnt_ff >= RD_WAIT)
    else $error("read turnaround too short");
  chk_pd_quiet: assert property (pd |-> sclk && $stable(sclk))
    else $error("clock moved while powered down");
  chk_pd_release: assert property (pd[*5] |-> !sdio_d_oe)
    else $error("sensor drives while powered down");
  chk_dev_release: assert property ($fell(sdio_d_oe) |->
    !sclk || pd)
    else $error("sensor released wire early");
  chk_dev_take: assert property ($rose(sdio_d_oe) |->
    !sclk && !sdio_h_oe)
    else $error("sensor took wire at wrong moment");

  cov_read: cover property ($rose(sdio_d_oe));
  cov_pd: cover property ($rose(pd));
  cov_turn: cover property (turn_ff && !sclk);
endmodule : stw_link_sva

`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for both ends of the two-wire serial port
`timescale 1ns/1ns
`default_nettype none

module tb;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identity value
  localparam int TMO = 2000;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic pd_req = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, pd_active, upd_valid, upd_valid2;
  logic [7:0] rsp_data, upd_data, upd_data2;
  logic [6:0] upd_addr, upd_addr2;
  logic busy, busy2;
  logic [15:0] frm = 16'h0000;
  logic [7:0] mdl [0:127];
  int bad_count = 0;
  int n_compared = 0;
  int upd_cnt = 0;
  int upd_cnt2 = 0;

  stw_link_if lnk();
  stw_link_if lnk2();

  stw_host #(.RD_WAIT(40), .WR_GAP(40), .PD_MIN(20)) stw_host_i (
    .lnk(lnk), .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pd_req(pd_req), .pd_active(pd_active));
  stw_dev #(.TMO_CYC(TMO), .ID_VAL(ID)) stw_dev_i (
    .lnk(lnk), .sys_clk(sys_clk), .resetn(resetn), .upd_valid(upd_valid),
    .upd_addr(upd_addr), .upd_data(upd_data), .port_busy(busy));
  stw_dev #(.TMO_CYC(TMO), .ID_VAL(ID)) stw_dev_i2 (
    .lnk(lnk2), .sys_clk(sys_clk), .resetn(resetn), .upd_valid(upd_valid2),
    .upd_addr(upd_addr2), .upd_data(upd_data2), .port_busy(busy2));
  stw_link_sva #(.RD_WAIT(40)) stw_link_sva_i (
    .sys_clk(sys_clk), .resetn(resetn), .sclk(lnk.sclk), .pd(lnk.pd),
    .sdio_h_o(lnk.sdio_h_o), .sdio_h_oe(lnk.sdio_h_oe),
    .sdio_d_o(lnk.sdio_d_o), .sdio_d_oe(lnk.sdio_d_oe));

  // clock, frame capture on the wire, update counters
  always #10 sys_clk = ~sys_clk;
  always @(posedge lnk.sclk) frm <= {frm[14:0], lnk.sdio};
  always @(posedge sys_clk) begin
    if (upd_valid === 1'b1) upd_cnt <= upd_cnt + 1;
    if (upd_valid2 === 1'b1) upd_cnt2 <= upd_cnt2 + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one command through the host, judged on ports and wire
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    int k;
    logic hit;
    n = upd_cnt;
    k = 0;
    hit = w && a != 7'h00 && a < 7'h10;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(16'(k >= 3000), 16'h0000);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = 0;
    while ((w ? cmd_ready : rsp_valid) !== 1'b1 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(16'(k >= 3000), 16'h0000);
    chk(16'(busy), 16'h0000);
    if (w) begin
      chk(16'(upd_cnt - n), 16'(hit));
      if (hit) mdl[a] = d;
      if (hit) chk(16'({upd_addr, upd_data}), 16'({a, d}));
      chk(frm, {1'b1, a, d});
    end else begin
      chk(16'(rsp_data), 16'(mdl[a]));
      chk(frm, {1'b0, a, mdl[a]});
    end
  endtask : xfer

  // bench-made link clock of 125 ns on the second sensor
  task automatic bang(input logic [15:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      lnk2.sclk = 1'b0;
      lnk2.sdio_h_oe = 1'b1;
      lnk2.sdio_h_o = f[15 - i];
      #62;
      lnk2.sclk = 1'b1;
      #63;
    end
  endtask : bang

  task automatic t_regs;
    xfer(1'b1, 7'h01, 8'hA5);
    xfer(1'b1, 7'h0F, 8'h3C);
    xfer(1'b1, 7'h05, 8'h96);
    xfer(1'b0, 7'h01, 8'h00);
    xfer(1'b0, 7'h0F, 8'h00);
    xfer(1'b0, 7'h05, 8'h00);
  endtask : t_regs

  task automatic t_unmapped;
    xfer(1'b1, 7'h00, 8'hFF);
    xfer(1'b0, 7'h00, 8'h00);
    xfer(1'b1, 7'h10, 8'h77);
    xfer(1'b0, 7'h10, 8'h00);
    xfer(1'b0, 7'h7F, 8'h00);
  endtask : t_unmapped

  task automatic t_pd;
    int k;
    k = 0;
    xfer(1'b0, 7'h05, 8'h00);
    chk(16'({lnk.sdio_d_oe, lnk.sdio}), 16'({1'b1, mdl[5][0]}));
    xfer(1'b1, 7'h02, 8'h5A);
    chk(16'(lnk.sdio_d_oe), 16'h0000);
    xfer(1'b0, 7'h02, 8'h00);
    pd_req = 1'b1;
    @(negedge sys_clk);
    chk(16'(cmd_ready), 16'h0000);
    while (pd_active !== 1'b1 && k < 50) begin
      @(negedge sys_clk);
      k++;
    end
    chk(16'(pd_active), 16'h0001);
    repeat (8) @(negedge sys_clk);
    chk(16'(lnk.sdio_d_oe), 16'h0000);
    pd_req = 1'b0;
    xfer(1'b0, 7'h02, 8'h00);
  endtask : t_pd

  // broken frames on the second link: pd abort, then timeout
  task automatic t_resync;
    int n;
    n = upd_cnt2;
    bang(16'h83C3, 5);
    lnk2.pd = 1'b1;
    repeat (100) @(negedge sys_clk);
    lnk2.pd = 1'b0;
    repeat (10) @(negedge sys_clk);
    bang(16'h83C3, 16);
    repeat (20) @(negedge sys_clk);
    chk(16'(upd_cnt2 - n), 16'h0001);
    chk(16'({upd_addr2, upd_data2}), 16'h03C3);
    bang(16'h8496, 9);
    repeat (10) @(negedge sys_clk);
    chk(16'(busy2), 16'h0001);
    repeat (TMO + 190) @(negedge sys_clk);
    bang(16'h8496, 16);
    repeat (20) @(negedge sys_clk);
    chk(16'(upd_cnt2 - n), 16'h0002);
    chk(16'({upd_addr2, upd_data2}), 16'h0496);
    chk(16'(lnk2.sdio_d_oe), 16'h0000);
    chk(16'(busy2), 16'h0000);
  endtask : t_resync

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    lnk2.sclk = 1'b1;
    lnk2.pd = 1'b0;
    lnk2.sdio_h_o = 1'b1;
    lnk2.sdio_h_oe = 1'b0;
    for (int i = 0; i < 128; i++) mdl[i] = 8'h00;
    mdl[0] = ID;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    t_regs;
    t_unmapped;
    t_pd;
    t_resync;
    complete_run;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    complete_run;
  end
endmodule : tb

`default_nettype wire
